// ==== hw/flw_pin_cycle.sv ====
// one timed write or read cycle on the flash strobes and byte bus
`timescale 1ns/10ps
`default_nettype none
module flw_pin_cycle (
	// clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rst_in,
	// request from the sequencer
	input  wire logic              start_in,
	input  wire flw_pkg::flw_req_t req_in,
	output logic                   done_out,
	output logic [7:0]             rdata_out,
	// flash pins
	output flw_pkg::flw_pins_t     pins_out,
	input  wire logic [7:0]        bus_in
);
	import flw_pkg::*;

	typedef enum logic [5:0] {
		E_IDLE  = 6'h01,
		E_SETUP = 6'h02,
		E_PULSE = 6'h04,
		E_HOLD  = 6'h08,
		E_ACC   = 6'h10,
		E_GAP   = 6'h20
	} flw_eng_t;

	flw_eng_t       st_q;
	logic           brief_q;
	logic           tload;
	logic [TMR_W-1:0] tcount;
	logic           tdone;

	flw_timer #(.W(TMR_W)) u_tmr (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.load_in  (tload),
		.count_in (tcount),
		.done_out (tdone)
	);

	always_comb begin
		tload = 1'b0;
		tcount = '0;
		unique case (st_q)
			E_IDLE: begin
				tload = start_in;
				tcount = req_in.wr ? TMR_W'(CYC_DS) : TMR_W'(CYC_ACC);
			end
			E_SETUP: begin
				tload = tdone;
				tcount = TMR_W'(CYC_WEP);
			end
			E_PULSE: begin
				tload = tdone;
				tcount = TMR_W'(CYC_AH);
			end
			// block data bytes only need the bus release gap; commands keep the long recovery
			E_HOLD: begin
				tload = tdone;
				tcount = brief_q ? TMR_W'(CYC_DF) : TMR_W'(CYC_NXTC);
			end
			// bus release time before anyone drives the byte bus again
			E_ACC: begin
				tload = tdone;
				tcount = TMR_W'(CYC_DF);
			end
			E_GAP: begin
				tload = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			st_q <= E_IDLE;
			brief_q <= 1'b0;
			pins_out <= PINS_IDLE;
			done_out <= 1'b0;
			rdata_out <= '0;
		end else begin
			done_out <= 1'b0;
			unique case (st_q)
				E_IDLE: begin
					if (start_in) begin
						brief_q <= req_in.brief;
						pins_out.addr <= req_in.addr;
						pins_out.ce_n <= 1'b0;
						if (req_in.wr) begin
							pins_out.dout <= req_in.data;
							pins_out.doe <= 1'b1;
							st_q <= E_SETUP;
						end else begin
							pins_out.oe_n <= 1'b0;
							st_q <= E_ACC;
						end
					end
				end
				E_SETUP: begin
					if (tdone) begin
						pins_out.we_n <= 1'b0;
						st_q <= E_PULSE;
					end
				end
				// device latches on the rising write strobe
				E_PULSE: begin
					if (tdone) begin
						pins_out.we_n <= 1'b1;
						st_q <= E_HOLD;
					end
				end
				E_HOLD: begin
					if (tdone) begin
						pins_out.ce_n <= 1'b1;
						pins_out.doe <= 1'b0;
						st_q <= E_GAP;
					end
				end
				E_ACC: begin
					if (tdone) begin
						rdata_out <= bus_in;
						pins_out.oe_n <= 1'b1;
						pins_out.ce_n <= 1'b1;
						st_q <= E_GAP;
					end
				end
				E_GAP: begin
					if (tdone) begin
						done_out <= 1'b1;
						st_q <= E_IDLE;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== hw/flw_pkg.sv ====
// constants, types and pin bundles for the flash writer-mode host controller
package flw_pkg;
	// software register offsets (byte addresses, one word each)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_BUF  = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	// status and control word fields
	localparam int ST_LAST_MSB = 7;
	localparam int ST_BUSY     = 8;
	localparam int ST_NORMAL   = 9;
	localparam int ST_END      = 10;
	localparam int ST_REFUSED  = 11;
	localparam int ST_RDMODE   = 12;
	localparam int CTRL_OP_MSB = 2;
	typedef enum logic [2:0] {
		OP_NONE     = 3'h0,
		OP_READMODE = 3'h1,
		OP_READ     = 3'h2,
		OP_PROGRAM  = 3'h3,
		OP_ERASE    = 3'h4,
		OP_STATUS   = 3'h5
	} flw_op_t;
	// device command codes and data values
	localparam logic [7:0] CODE_READ   = 8'h00;
	localparam logic [7:0] CODE_PROG   = 8'h40;
	localparam logic [7:0] CODE_ERASE  = 8'h20;
	localparam logic [7:0] CODE_STATUS = 8'h71;
	localparam logic [7:0] FILL_BYTE   = 8'hFF;
	localparam logic [7:0] ALIGN_LO    = 8'h00;
	localparam logic [7:0] ALIGN_HI    = 8'h80;
	localparam int BLOCK_BYTES = 128;
	localparam int BLK_LSB     = 7;
	localparam int BIT_END     = 7;
	localparam int BIT_NORMAL  = 6;
	localparam int ADDR_W      = 18;
	localparam int FILL_W      = 8;
	// timing, in printed units, and derived cycle counts (minimums round up)
	localparam int CLK_PS    = 5000;
	localparam int T_DS_NS   = 50;
	localparam int T_WEP_NS  = 70;
	localparam int T_AH_NS   = 60;
	localparam int T_DF_NS   = 100;
	localparam int T_NXTC_US = 20;
	localparam int T_ACC_US  = 20;
	localparam int T_WSTS_MS = 1;
	localparam int CYC_DS    = (T_DS_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CYC_WEP   = (T_WEP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CYC_AH    = (T_AH_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CYC_DF    = (T_DF_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CYC_NXTC  = (T_NXTC_US * 1000000 + CLK_PS - 1) / CLK_PS;
	localparam int CYC_ACC   = (T_ACC_US * 1000000 + CLK_PS - 1) / CLK_PS;
	localparam int CYC_WSTS  = (T_WSTS_MS * 1000000000 + CLK_PS - 1) / CLK_PS;
	localparam int TMR_W      = 13;
	localparam int TMR_POLL_W = 18;
	// flash pins as driven by the host
	typedef struct packed {
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        dout;
		logic              doe;
	} flw_pins_t;
	// one bus cycle request
	typedef struct packed {
		logic              wr;
		logic              brief;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} flw_req_t;
	localparam flw_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dout: '0, doe: 1'b0};
endpackage

// ==== hw/flw_timer.sv ====
// loadable down counter used for every wait in the controller
`timescale 1ns/10ps
`default_nettype none
module flw_timer #(
	parameter int W = 13
) (
	// clock and reset
	input  wire logic         mclk_in,
	input  wire logic         rst_in,
	// load and expiry
	input  wire logic         load_in,
	input  wire logic [W-1:0] count_in,
	output logic              done_out
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			cnt_q <= '0;
		end else if (load_in) begin
			cnt_q <= count_in;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign done_out = (cnt_q == '0);
endmodule
`default_nettype wire

// ==== hw/flw_writer_host.sv ====
// writer-mode flash programmer: AHB-Lite registers, command sequencer, block buffer
//
// What this block does
// - memory-read command is one write of 00, then any number of reads
// - auto-program is code 40 then 128 data writes, 129 writes total
// - erase is code 20 written twice; status read is 71 written twice
// - after program, erase or status read, reissue read command before array reads
// - wait at least 1 ms after last program write before polling
// - send the block as 128 back-to-back byte writes after the code
// - unused block positions are sent as FF
// - block address low byte must be 00 or 80
// - block address taken in second cycle; no new address afterwards
// - no command writes while an auto-program runs
// - program each 128-byte block only once (the code refuses only a repeat of the last programmed block, until an erase)
// - bit 6 means normal end, bit 7 operation end; success read from bit 6
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module flw_writer_host #(
	parameter int POLL_START_CYC = flw_pkg::CYC_WSTS
) (
	// clock and reset
	input  wire logic               mclk_in,
	input  wire logic               rst_in,
	// AHB-Lite slave
	input  wire logic               hsel_in,
	input  wire logic [31:0]        haddr_in,
	input  wire logic [1:0]         htrans_in,
	input  wire logic               hwrite_in,
	input  wire logic [2:0]         hsize_in,
	input  wire logic [31:0]        hwdata_in,
	input  wire logic               hready_in,
	output logic [31:0]             hrdata_out,
	output logic                    hreadyout_out,
	output logic                    hresp_out,
	// flash pins
	output flw_pkg::flw_pins_t      pins_out,
	input  wire logic [7:0]         flash_byte_bus_in
);
	import flw_pkg::*;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_CMD1 = 7'h02,
		S_CMD2 = 7'h04,
		S_DATA = 7'h08,
		S_WAIT = 7'h10,
		S_POLL = 7'h20,
		S_READ = 7'h40
	} flw_seq_t;

	localparam int BLK_W = ADDR_W - BLK_LSB;

	logic                  aphase;
	logic                  wr_pend_q;
	logic [7:0]            wr_addr_q;
	logic                  wr_ctrl;
	logic                  wr_addr;
	logic                  wr_buf;
	flw_op_t               op_new;
	logic                  misalign;
	logic                  repeat_blk;
	logic                  op_valid;
	logic                  accept;
	logic                  refuse;
	flw_seq_t              state_q;
	flw_op_t               op_q;
	logic                  pend_q;
	logic [FILL_W-1:0]     idx_q;
	logic [ADDR_W-1:0]     addr_q;
	logic [ADDR_W-1:0]     blk_q;
	logic [7:0]            buf_q [BLOCK_BYTES];
	logic [FILL_W-1:0]     fill_q;
	logic                  buf_clr;
	logic                  read_mode_q;
	logic                  normal_q;
	logic                  end_q;
	logic                  refused_q;
	logic                  prog_seen_q;
	logic [BLK_W-1:0]      prog_blk_q;
	logic [7:0]            last_q;
	logic                  eng_start;
	logic                  eng_done;
	logic [7:0]            eng_rdata;
	flw_req_t              req;
	logic [7:0]            code_w;
	logic                  last_byte;
	logic                  ptmr_load;
	logic                  ptmr_done;
	logic [31:0]           stat_w;

	// bus slave: zero wait states, writes land at the end of the data phase
	assign aphase = hsel_in & htrans_in[1] & hready_in;
	assign wr_ctrl = wr_pend_q & (wr_addr_q == REG_CTRL);
	assign wr_addr = wr_pend_q & (wr_addr_q == REG_ADDR);
	assign wr_buf = wr_pend_q & (wr_addr_q == REG_BUF);
	assign op_new = flw_op_t'(hwdata_in[CTRL_OP_MSB:0]);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end else begin
			wr_pend_q <= aphase & hwrite_in;
			wr_addr_q <= haddr_in[7:0];
		end
	end

	assign stat_w = {19'h0, read_mode_q, refused_q, end_q, normal_q, (state_q != S_IDLE), last_q};

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			hrdata_out <= '0;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			if (aphase & ~hwrite_in) begin
				case (haddr_in[7:0])
					REG_CTRL: hrdata_out <= {29'h0, op_q};
					REG_ADDR: hrdata_out <= {14'h0, addr_q};
					REG_BUF:  hrdata_out <= {24'h0, fill_q};
					REG_STAT: hrdata_out <= stat_w;
					default:  hrdata_out <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			addr_q <= '0;
		end else if (wr_addr) begin
			addr_q <= hwdata_in[ADDR_W-1:0];
		end
	end

	// start checks; a start while busy is dropped so no command can break a running program
	assign misalign = (addr_q[7:0] != ALIGN_LO) && (addr_q[7:0] != ALIGN_HI);
	assign repeat_blk = prog_seen_q && (addr_q[ADDR_W-1:BLK_LSB] == prog_blk_q);
	assign op_valid = op_new inside {OP_READMODE, OP_READ, OP_PROGRAM, OP_ERASE, OP_STATUS};
	assign refuse = wr_ctrl & (state_q == S_IDLE) & (~op_valid | ((op_new == OP_PROGRAM) & (misalign | repeat_blk)));
	assign accept = wr_ctrl & (state_q == S_IDLE) & ~refuse;

	// block buffer, refilled with FF after every program so short blocks pad themselves
	assign buf_clr = ptmr_load & (op_q == OP_PROGRAM);

	always_ff @(posedge mclk_in) begin
		if (rst_in || buf_clr) begin
			for (int i = 0; i < BLOCK_BYTES; i++) begin
				buf_q[i] <= FILL_BYTE;
			end
			fill_q <= '0;
		end else if (wr_buf && (state_q == S_IDLE) && (fill_q < FILL_W'(BLOCK_BYTES))) begin
			buf_q[fill_q[BLK_LSB-1:0]] <= hwdata_in[7:0];
			fill_q <= fill_q + 1'b1;
		end
	end

	// command codes
	always_comb begin
		code_w = CODE_READ;
		if (op_q == OP_PROGRAM) begin
			code_w = CODE_PROG;
		end else if (op_q == OP_ERASE) begin
			code_w = CODE_ERASE;
		end else if (op_q == OP_STATUS) begin
			code_w = CODE_STATUS;
		end
	end

	// every cycle carries the block address, so it never changes after the second cycle
	always_comb begin
		req.wr = state_q inside {S_CMD1, S_CMD2, S_DATA};
		req.brief = (state_q == S_DATA);
		req.addr = blk_q;
		req.data = (state_q == S_DATA) ? buf_q[idx_q[BLK_LSB-1:0]] : code_w;
	end

	assign eng_start = ~pend_q & (state_q inside {S_CMD1, S_CMD2, S_DATA, S_POLL, S_READ});
	assign last_byte = (idx_q == FILL_W'(BLOCK_BYTES - 1));
	assign ptmr_load = eng_done & (((state_q == S_DATA) & last_byte) | ((state_q == S_CMD2) & (op_q == OP_ERASE)));

	flw_pin_cycle u_cycle (
		.mclk_in   (mclk_in),
		.rst_in    (rst_in),
		.start_in  (eng_start),
		.req_in    (req),
		.done_out  (eng_done),
		.rdata_out (eng_rdata),
		.pins_out  (pins_out),
		.bus_in    (flash_byte_bus_in)
	);

	flw_timer #(.W(TMR_POLL_W)) u_poll_tmr (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.load_in  (ptmr_load),
		.count_in (TMR_POLL_W'(POLL_START_CYC)),
		.done_out (ptmr_done)
	);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			pend_q <= 1'b0;
		end else if (eng_start) begin
			pend_q <= 1'b1;
		end else if (eng_done) begin
			pend_q <= 1'b0;
		end
	end

	// sequencer
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_q <= S_IDLE;
			op_q <= OP_NONE;
			idx_q <= '0;
			blk_q <= '0;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (accept) begin
						op_q <= op_new;
						blk_q <= addr_q;
						idx_q <= '0;
						state_q <= ((op_new == OP_READ) && read_mode_q) ? S_READ : S_CMD1;
					end
				end
				S_CMD1: begin
					if (eng_done) begin
						unique case (op_q)
							OP_READMODE: state_q <= S_IDLE;
							OP_READ:     state_q <= S_READ;
							OP_PROGRAM:  state_q <= S_DATA;
							default:     state_q <= S_CMD2;
						endcase
					end
				end
				S_CMD2: begin
					if (eng_done) begin
						state_q <= (op_q == OP_ERASE) ? S_WAIT : S_READ;
					end
				end
				S_DATA: begin
					if (eng_done) begin
						idx_q <= idx_q + 1'b1;
						if (last_byte) begin
							state_q <= S_WAIT;
						end
					end
				end
				S_WAIT: begin
					if (ptmr_done) begin
						state_q <= S_POLL;
					end
				end
				// erase can take tens of seconds; polling has no limit of its own
				S_POLL: begin
					if (eng_done && eng_rdata[BIT_END]) begin
						state_q <= S_IDLE;
					end
				end
				S_READ: begin
					if (eng_done) begin
						state_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	// device-side view and results
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			read_mode_q <= 1'b1;
			normal_q <= 1'b0;
			end_q <= 1'b0;
			last_q <= '0;
		end else begin
			if (eng_done && (state_q == S_CMD1)) begin
				read_mode_q <= op_q inside {OP_READMODE, OP_READ};
				normal_q <= 1'b0;
				end_q <= 1'b0;
			end
			if (eng_done && (state_q inside {S_POLL, S_READ})) begin
				last_q <= eng_rdata;
			end
			if (eng_done && (state_q == S_POLL) && eng_rdata[BIT_END]) begin
				end_q <= 1'b1;
				normal_q <= eng_rdata[BIT_NORMAL];
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			refused_q <= 1'b0;
			prog_seen_q <= 1'b0;
			prog_blk_q <= '0;
		end else begin
			if (refuse) begin
				refused_q <= 1'b1;
			end else if (accept) begin
				refused_q <= 1'b0;
			end
			if (accept && (op_new == OP_PROGRAM)) begin
				prog_seen_q <= 1'b1;
				prog_blk_q <= addr_q[ADDR_W-1:BLK_LSB];
			end else if (accept && (op_new == OP_ERASE)) begin
				prog_seen_q <= 1'b0;
			end
		end
	end

	// checking helpers
	logic [FILL_W:0]         data_cnt_q;
	logic [TMR_POLL_W-1:0]   wait_cnt_q;

	always_ff @(posedge mclk_in) begin
		if (rst_in || (state_q == S_IDLE)) begin
			data_cnt_q <= '0;
		end else if (eng_done && (state_q == S_DATA)) begin
			data_cnt_q <= data_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in || (state_q != S_WAIT)) begin
			wait_cnt_q <= '0;
		end else begin
			wait_cnt_q <= wait_cnt_q + 1'b1;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	a_prog_code: assert property ((state_q == S_CMD1) && (op_q == OP_PROGRAM) && $fell(pins_out.we_n) |-> pins_out.dout == CODE_PROG && pins_out.doe) else $error("program code wrong");
	a_erase_second: assert property ((state_q == S_CMD2) && (op_q == OP_ERASE) && $fell(pins_out.we_n) |-> pins_out.dout == CODE_ERASE) else $error("erase second code wrong");
	a_block_count: assert property ($rose(state_q == S_WAIT) && (op_q == OP_PROGRAM) |-> data_cnt_q == 9'(BLOCK_BYTES)) else $error("block not 128 bytes");
	a_poll_delay: assert property ($fell(state_q == S_WAIT) |-> wait_cnt_q >= TMR_POLL_W'(POLL_START_CYC)) else $error("polling began early");
	a_no_cmd_busy: assert property ((state_q inside {S_WAIT, S_POLL}) |-> pins_out.we_n && !pins_out.doe) else $error("write during program");
	a_addr_hold: assert property ((state_q == S_DATA) && !pins_out.ce_n |-> pins_out.addr == blk_q && $stable(pins_out.addr)) else $error("block address moved");
	a_align_refuse: assert property (wr_ctrl && (state_q == S_IDLE) && (op_new == OP_PROGRAM) && misalign |=> (state_q == S_IDLE) && refused_q) else $error("misaligned program started");
	a_read_mode: assert property ((state_q == S_READ) && (op_q == OP_READ) && !pins_out.oe_n |-> read_mode_q) else $error("array read outside read mode");
	a_normal_flag: assert property (eng_done && (state_q == S_POLL) && eng_rdata[BIT_END] |=> end_q && (normal_q == $past(eng_rdata[BIT_NORMAL])) && (state_q == S_IDLE)) else $error("end flags not taken");
	a_pad_fill: assert property (buf_clr |=> buf_q[BLOCK_BYTES - 1] == FILL_BYTE && fill_q == '0) else $error("buffer not refilled");

	c_program_done: cover property ($fell(state_q == S_POLL) && (op_q == OP_PROGRAM) && normal_q);
	c_erase_done: cover property ($fell(state_q == S_POLL) && (op_q == OP_ERASE));
	c_status_read: cover property (eng_done && (state_q == S_READ) && (op_q == OP_STATUS));
	c_array_read: cover property (eng_done && (state_q == S_READ) && (op_q == OP_READ));
endmodule
`default_nettype wire

// ==== tb/flw_dev_model.sv ====
// behavioural writer-mode flash device on the host pins
`timescale 1ns/10ps
`default_nettype none
module flw_dev_model (
	// host pins
	input  wire logic               mclk_in,
	input  wire flw_pkg::flw_pins_t pins_in,
	// byte bus drive
	output logic                    drv_out,
	output logic [7:0]              data_out
);
	import flw_pkg::*;
	logic       we_q     = 1'b1;
	logic [1:0] mode_q   = 2'h1;
	logic [7:0] pend_q   = 8'h00;
	logic [7:0] poll_q   = 8'h00;
	logic [7:0] stat_q   = 8'h00;
	logic [7:0] cnt_q    = 8'h00;
	logic [7:0] busy_q   = 8'h00;
	logic [3:0] settle_q = 4'hA;
	logic       err_q    = 1'b0;
	wire        wr_rise;
	assign wr_rise = !pins_in.ce_n && pins_in.oe_n && pins_in.we_n && !we_q;
	assign drv_out = !pins_in.ce_n && !pins_in.oe_n;
	always_comb begin
		case (mode_q)
			2'h1: data_out = pins_in.addr[7:0] ^ 8'hA5;
			2'h2: data_out = poll_q;
			2'h3: data_out = stat_q;
			default: data_out = 8'h00;
		endcase
	end
	// keeps running whatever ce_n does
	always_ff @(posedge mclk_in) begin
		we_q <= pins_in.we_n;
		// short stand-in for settling; strobes before it ends are dropped
		if (settle_q != 4'h0) begin
			settle_q <= settle_q - 4'h1;
		end
		if (busy_q != 8'h00) begin
			busy_q <= busy_q - 8'h01;
			if (busy_q == 8'h01) begin
				poll_q <= {1'b1, !err_q, 6'h00};
				stat_q <= err_q ? 8'hA1 : 8'h00;
			end
		end
		if (wr_rise && (settle_q == 4'h0)) begin
			if (cnt_q != 8'h00) begin
				if (cnt_q == 8'h80 && pins_in.addr[6:0] != 7'h00) err_q <= 1'b1;
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h01) busy_q <= 8'h28;
			end else if (pend_q != 8'h00 && pins_in.dout == pend_q) begin
				pend_q <= 8'h00;
				mode_q <= (pend_q == CODE_STATUS) ? 2'h3 : 2'h2;
				if (pend_q == CODE_ERASE) busy_q <= 8'h28;
			end else begin
				pend_q <= 8'h00;
				poll_q <= 8'h00;
				case (pins_in.dout)
					CODE_READ: mode_q <= 2'h1;
					CODE_PROG: begin
						cnt_q  <= 8'h80;
						err_q  <= 1'b0;
						mode_q <= 2'h2;
					end
					CODE_ERASE, CODE_STATUS: pend_q <= pins_in.dout;
					default: stat_q <= 8'hC0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/flw_writer_host_test.sv ====
// self-checking bench for the writer-mode flash host
`timescale 1ns/10ps
`default_nettype none
module flw_writer_host_test;
	import flw_pkg::*;
	logic        mclk_in;
	logic        rst_in;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	flw_pins_t   pins;
	logic        drv;
	logic [7:0]  ddata;
	logic [7:0]  bus;
	logic [7:0]  bus_q = 8'h00;
	logic        we_q  = 1'b1;
	logic [7:0]  wq[$];
	logic [17:0] aq[$];
	logic        hresp;
	int          failures;
	int          n_tests;
	flw_writer_host #(.POLL_START_CYC(50)) flw_writer_host_inst (
		.mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.pins_out(pins), .flash_byte_bus_in(bus));
	flw_dev_model flw_dev_model_inst (.mclk_in(mclk_in), .pins_in(pins), .drv_out(drv), .data_out(ddata));
	// released bus toggles so stale data cannot pass
	assign bus = pins.doe ? pins.dout : (drv ? ddata : ~bus_q);
	always @(posedge mclk_in) begin
		bus_q <= bus;
		we_q <= pins.we_n;
		if (pins.we_n && !we_q && !pins.ce_n) begin
			wq.push_back(pins.dout);
			aq.push_back(pins.addr);
			check({30'h0, pins.oe_n, pins.doe}, 32'h3);
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("comparisons=%0d mismatches=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wait_rdy;
		int i;
		i = 0;
		@(posedge mclk_in);
		while (hready !== 1'b1) begin
			i++;
			if (i > 100) begin
				failures++;
				test_done;
			end
			@(posedge mclk_in);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		xfer(1'b0, a, 32'h0, d);
	endtask
	// start an operation and poll until it is no longer busy
	task automatic run(input logic [2:0] op, output logic [31:0] st);
		int i;
		wq.delete();
		aq.delete();
		wr(REG_CTRL, {29'h0, op});
		i = 0;
		do begin
			rd(REG_STAT, st);
			i++;
			if (i > 20000) begin
				failures++;
				test_done;
			end
		end while (st[ST_BUSY] !== 1'b0);
	endtask
	task automatic t_reset;
		logic [31:0] v;
		rd(REG_STAT, v);
		check(v & 32'h1F00, 32'h1000);
		check({29'h0, pins.ce_n, pins.we_n, pins.doe}, 32'h6);
		rd(REG_BUF, v);
		check(v, 32'h0);
		rd(8'h10, v);
		check(v, 32'h0);
		wr(REG_ADDR, 32'hFFFFFFFF);
		rd(REG_ADDR, v);
		check(v, 32'h3FFFF);
		$display("reset test done");
	endtask
	task automatic t_read(input logic [31:0] a, input int nw);
		logic [31:0] v;
		wr(REG_ADDR, a);
		run(OP_READ, v);
		check(32'(wq.size()), 32'(nw));
		if (nw > 0) check({24'h0, wq[0]}, {24'h0, CODE_READ});
		check({24'h0, v[7:0]}, {24'h0, a[7:0] ^ 8'hA5});
		$display("read test done");
	endtask
	task automatic t_cmd2(input logic [2:0] op, input logic [7:0] code, input logic [31:0] exp);
		logic [31:0] v;
		run(op, v);
		check(32'(wq.size()), 32'h2);
		check({wq[0], wq[1]}, {code, code});
		check(v & 32'h16FF, exp);
		$display("two-write command test done");
	endtask
	task automatic t_readmode;
		logic [31:0] v;
		run(OP_READMODE, v);
		check(32'(wq.size()), 32'h1);
		check({24'h0, wq[0]}, {24'h0, CODE_READ});
		check(v & 32'h1600, 32'h1000);
		$display("read mode test done");
	endtask
	task automatic t_refuse;
		logic [31:0] v;
		wr(REG_BUF, 32'h11);
		wr(REG_BUF, 32'h22);
		wr(REG_BUF, 32'h33);
		rd(REG_BUF, v);
		check(v, 32'h3);
		wr(REG_ADDR, 32'h00041);
		run(OP_PROGRAM, v);
		check({31'h0, v[ST_REFUSED]}, 32'h1);
		check(32'(wq.size()), 32'h0);
		run(3'h7, v);
		check({31'h0, v[ST_REFUSED]}, 32'h1);
		check(32'(wq.size()), 32'h0);
		$display("refusal test done");
	endtask
	// program the three bytes left in the buffer, then try the same block again
	task automatic t_prog;
		logic [31:0] v;
		wr(REG_ADDR, 32'h00180);
		run(OP_PROGRAM, v);
		check(32'(wq.size()), 32'h81);
		check({24'h0, wq[0]}, {24'h0, CODE_PROG});
		check({wq[1], wq[2], wq[3], wq[4]}, 32'h112233FF);
		check({24'h0, wq[128]}, {24'h0, FILL_BYTE});
		check({14'h0, aq[1]}, 32'h00180);
		check({14'h0, aq[128]}, 32'h00180);
		check(v & 32'h16FF, 32'h06C0);
		rd(REG_BUF, v);
		check(v, 32'h0);
		run(OP_PROGRAM, v);
		check({31'h0, v[ST_REFUSED]}, 32'h1);
		check(32'(wq.size()), 32'h0);
		$display("program test done");
	endtask
	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end
	initial begin
		failures = 0;
		n_tests = 0;
		rst_in = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_reset;
		t_read(32'h00123, 0);
		t_read(32'h1FF80, 0);
		t_cmd2(OP_STATUS, CODE_STATUS, 32'h0000);
		t_cmd2(OP_ERASE, CODE_ERASE, 32'h06C0);
		t_read(32'h00456, 1);
		t_readmode;
		t_read(32'h0007E, 0);
		t_refuse;
		t_prog;
		test_done;
	end
endmodule
`default_nettype wire
